/* File: verilog/rssi_ook_threshold_demod.sv */
// Purpose: signal-strength estimate, strength interrupt, on-off and fsk demod
// Assumes: analog chain delivers level samples in 0.5 dB steps and a phase sign
// Notes: raw data only; bit timing recovery sits outside this block
`timescale 1ns/100ps
`default_nettype none
module rssi_ook_threshold_demod
    import strength_pkg::*;
#(
    parameter int LEVEL_WIDTH = LEVEL_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    // analog side
    input wire logic [LEVEL_WIDTH-1:0] levelSample,
    input wire logic phaseLead,
    // configuration
    input wire logic onOffMode,
    input wire logic [7:0] deviationSetting,
    input wire logic [7:0] bitRateSetting,
    input wire logic [LEVEL_WIDTH-1:0] strengthIrqLevel,
    input wire logic strengthIrqClear,
    input wire logic irqRoutePinA,
    input wire logic irqRoutePinB,
    input wire logic [1:0] onoffThresholdKind,
    input wire logic [2:0] onoffDecayStep,
    input wire logic [2:0] onoffDecayInterval,
    input wire logic [1:0] onoffAverageCutoff,
    input wire logic [LEVEL_WIDTH-1:0] onoffFloorLevel,
    input wire logic polyphaseFilterEnable,
    input wire logic [3:0] polyphaseCenterFreq,
    input wire logic [3:0] activeFilterCutoff,
    input wire logic [3:0] passiveFilterBw,
    // results
    output logic [LEVEL_WIDTH-1:0] signalStrengthValue,
    output logic strengthIrqFlag,
    output logic interruptPinA,
    output logic interruptPinB,
    output logic [LEVEL_WIDTH-1:0] onoffThreshold,
    output logic demodData,
    output logic sampleStrobe,
    // filter controls toward the analog chain
    output logic polyphaseOn,
    output logic lowPassOn,
    output logic [3:0] filterCenterCode,
    output logic [3:0] filterCutoffCode,
    output logic [3:0] passiveBwCode
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        // rate dividers
        logic [9:0] sampleCnt;
        logic sampleEn;
        logic [17:0] decayCnt;
        // threshold tracking
        logic [8:0] peak;
        logic [15:0] avgAcc;
        // interrupt flag and pins
        logic irqFlag;
        logic pinA;
        logic pinB;
        // demod results
        logic data;
        logic [LEVEL_WIDTH-1:0] thresh;
        // filter controls
        logic polyOn;
        logic lpOn;
        logic [3:0] center;
        logic [3:0] cutoff;
        logic [3:0] passive;
    } demod_s;

    demod_s st_reg;
    demod_s st_next;

    // window result
    logic [LEVEL_WIDTH-1:0] mean;
    logic meanValid;
    // divider limits
    logic [9:0] sampleLimit;
    logic [9:0] chipBase;
    logic [17:0] decayLimit;
    // threshold arithmetic
    logic [8:0] decayAmount;
    logic [8:0] peakFloor;
    logic [8:0] peakLessMargin;
    logic [8:0] peakThresh;
    logic [8:0] decayed;
    logic [15:0] avgDelta;
    logic [LEVEL_WIDTH-1:0] avgLevel;
    logic [LEVEL_WIDTH-1:0] activeThresh;
    logic decayTick;
    logic onoffBit;

    // ****************************************
    // averaging window
    // ****************************************
    sliding_average #(
        .WIDTH(LEVEL_WIDTH)
    ) u_window (
        .clk_sys(clk_sys),
        .rst(rst),
        .sampleEn(st_reg.sampleEn),
        .sampleIn(levelSample),
        .meanOut(mean),
        .meanValid(meanValid)
    );

    // ****************************************
    // rate and level arithmetic
    // ****************************************
    // same divider serves both modes; deviation code sets the rate
    always_comb begin
        sampleLimit = 10'(DEV_DIVISOR * (32'(deviationSetting) + 1) - 1);
        chipBase = 10'(DECAY_BASE_DIV * (32'(bitRateSetting) + 1));
    end

    // ****************************************
    // decay tables
    // ****************************************

    // decay interval in sixteenths of a chip
    always_comb begin
        case (onoffDecayInterval)
            3'h0: decayLimit = {4'h0, chipBase, 4'h0};
            3'h1: decayLimit = {3'h0, chipBase, 5'h00};
            3'h2: decayLimit = {2'h0, chipBase, 6'h00};
            3'h3: decayLimit = {1'h0, chipBase, 7'h00};
            3'h4: decayLimit = {5'h00, chipBase, 3'h0};
            3'h5: decayLimit = {6'h00, chipBase, 2'h0};
            3'h6: decayLimit = {7'h00, chipBase, 1'h0};
            default: decayLimit = {8'h00, chipBase};
        endcase
    end

    // decay step in half-decibel units
    always_comb begin
        case (onoffDecayStep)
            3'h0: decayAmount = 9'h001;
            3'h1: decayAmount = 9'h002;
            3'h2: decayAmount = 9'h003;
            3'h3: decayAmount = 9'h004;
            3'h4: decayAmount = 9'h006;
            3'h5: decayAmount = 9'h008;
            3'h6: decayAmount = 9'h00A;
            default: decayAmount = 9'h00C;
        endcase
    end

    // ****************************************
    // threshold selection
    // ****************************************

    // threshold candidates for each kind
    always_comb begin
        peakFloor = {1'b0, onoffFloorLevel} + PEAK_MARGIN;
        peakLessMargin = (st_reg.peak > PEAK_MARGIN) ?
            st_reg.peak - PEAK_MARGIN : 9'h000;
        peakThresh = (peakLessMargin < {1'b0, onoffFloorLevel}) ?
            {1'b0, onoffFloorLevel} : peakLessMargin;
        decayed = (st_reg.peak > peakFloor + decayAmount) ?
            st_reg.peak - decayAmount : peakFloor;
        avgLevel = st_reg.avgAcc[15:16-LEVEL_WIDTH];
        avgDelta = {mean, {(16-LEVEL_WIDTH){1'b0}}} - st_reg.avgAcc;
        case (onoffThresholdKind)
            KIND_FIXED: activeThresh = onoffFloorLevel;
            KIND_PEAK: activeThresh = peakThresh[LEVEL_WIDTH-1:0];
            KIND_AVERAGE: activeThresh = avgLevel;
            default: activeThresh = peakThresh[LEVEL_WIDTH-1:0];
        endcase
        decayTick = (st_reg.decayCnt >= decayLimit - 18'h00001);
        onoffBit = (mean > activeThresh);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // ****************************************
        // sample strobe divider
        // ****************************************
        st_next.sampleEn = 1'b0;
        if (st_reg.sampleCnt >= sampleLimit) begin
            st_next.sampleCnt = 10'h000;
            st_next.sampleEn = 1'b1;
        end else begin
            st_next.sampleCnt = st_reg.sampleCnt + 10'h001;
        end

        // ****************************************
        // decay interval counter
        // ****************************************
        st_next.decayCnt = decayTick ? 18'h00000 : st_reg.decayCnt + 18'h00001;

        // ****************************************
        // peak tracking: reload wins over decay
        // ****************************************
        if (meanValid && ({1'b0, mean} > st_reg.peak)) begin
            st_next.peak = {1'b0, mean};
        end else if (decayTick && !st_reg.data) begin
            st_next.peak = decayed;
        end

        // ****************************************
        // average threshold: first-order filter of the strength
        // ****************************************
        if (meanValid) begin
            st_next.avgAcc = st_reg.avgAcc
                + 16'($signed(avgDelta) >>> (AVG_BASE_SHIFT + 32'(onoffAverageCutoff)));
        end

        // ****************************************
        // demod data, raw and unsynchronised
        // ****************************************
        if (meanValid) begin
            st_next.data = onOffMode ? onoffBit : phaseLead;
            st_next.thresh = activeThresh;
        end

        // ****************************************
        // strength interrupt: set beats a same-cycle clear
        // ****************************************
        if (strengthIrqClear) begin
            st_next.irqFlag = 1'b0;
        end
        if (meanValid && (mean > strengthIrqLevel)) begin
            st_next.irqFlag = 1'b1;
        end
        st_next.pinA = st_next.irqFlag & irqRoutePinA;
        st_next.pinB = st_next.irqFlag & irqRoutePinB;

        // ****************************************
        // channel filter controls
        // ****************************************
        st_next.polyOn = polyphaseFilterEnable;
        st_next.lpOn = ~polyphaseFilterEnable;
        st_next.center = polyphaseCenterFreq;
        st_next.cutoff = activeFilterCutoff;
        st_next.passive = passiveFilterBw;
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.peak <= PEAK_RESET;
            st_reg.avgAcc <= AVG_RESET;
            st_reg.lpOn <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign signalStrengthValue = mean;
    assign strengthIrqFlag = st_reg.irqFlag;
    assign interruptPinA = st_reg.pinA;
    assign interruptPinB = st_reg.pinB;
    assign onoffThreshold = st_reg.thresh;
    assign demodData = st_reg.data;
    assign sampleStrobe = st_reg.sampleEn;
    assign polyphaseOn = st_reg.polyOn;
    assign lowPassOn = st_reg.lpOn;
    assign filterCenterCode = st_reg.center;
    assign filterCutoffCode = st_reg.cutoff;
    assign passiveBwCode = st_reg.passive;

endmodule // rssi_ook_threshold_demod
`default_nettype wire

/* File: verilog/strength_pkg.sv */
// Purpose: shared constants for the signal-strength and on-off demod block
// Assumes: 10 MHz system clock stands in for the reference crystal
// Notes: levels are in half-decibel steps throughout
package strength_pkg;

    // ****************************************
    // widths and timing
    // ****************************************
    localparam int LEVEL_W = 8;               // strength in 0.5 dB steps
    localparam int WINDOW_LEN = 16;           // samples per sliding window
    localparam int WINDOW_SHIFT = 4;          // log2 of the window
    localparam int SAMPLES_PER_PERIOD = 16;   // samples per deviation period
    localparam int CLK_SYS_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    // sample rate = 16 * clk / (32 * (1 + dev)) = clk / (2 * (1 + dev))
    localparam int DEV_DIVISOR = 32 / SAMPLES_PER_PERIOD;
    // chip period = 64 * (1 + rate) cycles; decay base is one sixteenth
    localparam int CHIP_DIVISOR = 64;
    localparam int DECAY_BASE_DIV = CHIP_DIVISOR / 16;

    // ****************************************
    // reset values and fixed levels
    // ****************************************
    localparam logic [7:0] DEVIATION_RESET = 8'h03;  // 100 kHz second IF
    localparam logic [8:0] PEAK_MARGIN = 9'h00C;     // 6 dB in 0.5 dB steps
    localparam logic [8:0] PEAK_RESET = 9'h000;
    localparam logic [15:0] AVG_RESET = 16'h0000;
    localparam int AVG_BASE_SHIFT = 3;               // average filter base

    // ****************************************
    // threshold kinds
    // ****************************************
    localparam logic [1:0] KIND_FIXED = 2'h0;
    localparam logic [1:0] KIND_PEAK = 2'h1;
    localparam logic [1:0] KIND_AVERAGE = 2'h2;

endpackage

/* File: verilog/sliding_average.sv */
// Purpose: mean of the latest sixteen strength samples
// Assumes: sampleEn is a one-cycle pulse at the sample rate
// Notes: running sum avoids re-adding the whole window each sample
`timescale 1ns/100ps
`default_nettype none
module sliding_average
    import strength_pkg::*;
#(
    parameter int WIDTH = LEVEL_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sampleEn,
    input wire logic [WIDTH-1:0] sampleIn,
    output logic [WIDTH-1:0] meanOut,
    output logic meanValid
);

    typedef struct packed {
        logic [WINDOW_LEN-1:0][WIDTH-1:0] taps;
        logic [WINDOW_SHIFT-1:0] ptr;
        logic [WIDTH+WINDOW_SHIFT-1:0] sum;
        logic [WIDTH-1:0] mean;
        logic valid;
    } avg_s;

    avg_s st_reg;
    avg_s st_next;

    // window update: add newest, drop oldest, one sample at a time
    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        if (sampleEn) begin
            st_next.sum = st_reg.sum + {{WINDOW_SHIFT{1'b0}}, sampleIn}
                - {{WINDOW_SHIFT{1'b0}}, st_reg.taps[st_reg.ptr]};
            st_next.taps[st_reg.ptr] = sampleIn;
            st_next.ptr = st_reg.ptr + 1'b1;
            st_next.mean = st_next.sum[WIDTH+WINDOW_SHIFT-1:WINDOW_SHIFT];
            st_next.valid = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign meanOut = st_reg.mean;
    assign meanValid = st_reg.valid;

endmodule // sliding_average
`default_nettype wire

/* File: testbench/analog_chain_model.sv */
// Purpose: analog chain stand-in giving level samples and phase sign
// Assumes: levels in half-decibel steps
// Notes: follows the commanded signal one edge later
`timescale 1ns/100ps
`default_nettype none
module analog_chain_model (
    input wire logic clk_sys,
    input wire logic [7:0] targetLevel,
    input wire logic targetPhase,
    output logic [7:0] levelSample,
    output logic phaseLead
);
    // baseband level and phase follow the command
    always_ff @(posedge clk_sys) begin
        levelSample <= targetLevel;
        phaseLead <= targetPhase;
    end
endmodule // analog_chain_model
`default_nettype wire

/* File: testbench/rssi_ook_threshold_demod_props.sv */
// Purpose: port checks of the strength and on-off block
// Assumes: deviation setting held steady through a run
// Notes: bound to the block from tb_top
`timescale 1ns/100ps
`default_nettype none
module rssi_ook_threshold_demod_props
    import strength_pkg::*;
#(parameter int LEVEL_WIDTH = LEVEL_W) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] deviationSetting,
    input wire logic [LEVEL_WIDTH-1:0] strengthIrqLevel,
    input wire logic strengthIrqClear,
    input wire logic irqRoutePinA,
    input wire logic irqRoutePinB,
    input wire logic [1:0] onoffThresholdKind,
    input wire logic [LEVEL_WIDTH-1:0] onoffFloorLevel,
    input wire logic [LEVEL_WIDTH-1:0] signalStrengthValue,
    input wire logic strengthIrqFlag,
    input wire logic interruptPinA,
    input wire logic interruptPinB,
    input wire logic [LEVEL_WIDTH-1:0] onoffThreshold,
    input wire logic sampleStrobe,
    input wire logic polyphaseOn,
    input wire logic lowPassOn
);
    // ****************************************
    // strobe spacing
    // ****************************************
    logic [9:0] gapCount_reg;
    logic strobeSeen_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // cycles since the last strobe
    always_ff @(posedge clk_sys) begin
        gapCount_reg <= (rst || sampleStrobe) ? 10'h000 : gapCount_reg + 10'h001;
        strobeSeen_reg <= !rst && (strobeSeen_reg || sampleStrobe);
    end

    property p_rate;
        sampleStrobe && strobeSeen_reg |-> gapCount_reg == {1'h0, deviationSetting, 1'h1};
    endproperty
    a_rate: assert property (p_rate) else $error("strobe spacing wrong");
    property p_refresh; $changed(signalStrengthValue) |-> $past(sampleStrobe); endproperty
    a_refresh: assert property (p_refresh) else $error("strength moved off strobe");
    property p_set;
        $rose(strengthIrqFlag) |-> $past(signalStrengthValue) > $past(strengthIrqLevel);
    endproperty
    a_set: assert property (p_set) else $error("flag set below level");
    property p_clear; $fell(strengthIrqFlag) |-> $past(strengthIrqClear); endproperty
    a_clear: assert property (p_clear) else $error("flag fell without clear");
    property p_route;
        interruptPinA == (strengthIrqFlag && $past(irqRoutePinA))
            && interruptPinB == (strengthIrqFlag && $past(irqRoutePinB));
    endproperty
    a_route: assert property (p_route) else $error("pin routing wrong");
    property p_floor;
        $changed(onoffThreshold) && onoffThresholdKind != KIND_AVERAGE
            |-> onoffThreshold >= onoffFloorLevel;
    endproperty
    a_floor: assert property (p_floor) else $error("threshold under floor");
    property p_fixed;
        $changed(onoffThreshold) && onoffThresholdKind == KIND_FIXED
            |-> onoffThreshold == onoffFloorLevel;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed threshold wrong");
    property p_filter; polyphaseOn != lowPassOn; endproperty
    a_filter: assert property (p_filter) else $error("filter select wrong");
endmodule // rssi_ook_threshold_demod_props
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the strength and on-off block
// Assumes: analog stand-in supplies level and phase
// Notes: inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
`default_nettype none
module tb_top import strength_pkg::*;;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [3:0] CENTER_CODE = 4'h3; // centre code for 100 kHz
    logic clk_sys, rst, phaseLead, onOffMode, strengthIrqClear, irqRoutePinA, irqRoutePinB;
    logic polyphaseFilterEnable, targetPhase, strengthIrqFlag, interruptPinA, interruptPinB;
    logic demodData, sampleStrobe, polyphaseOn, lowPassOn;
    logic [7:0] levelSample, deviationSetting, bitRateSetting, strengthIrqLevel, targetLevel;
    logic [7:0] onoffFloorLevel, signalStrengthValue, onoffThreshold;
    logic [1:0] onoffThresholdKind, onoffAverageCutoff;
    logic [2:0] onoffDecayStep, onoffDecayInterval;
    logic [3:0] polyphaseCenterFreq, activeFilterCutoff, passiveFilterBw;
    logic [3:0] filterCenterCode, filterCutoffCode, passiveBwCode;
    int err_total, checked;

    rssi_ook_threshold_demod uut (
        .clk_sys, .rst, .levelSample, .phaseLead, .onOffMode, .deviationSetting,
        .bitRateSetting, .strengthIrqLevel, .strengthIrqClear, .irqRoutePinA, .irqRoutePinB,
        .onoffThresholdKind, .onoffDecayStep, .onoffDecayInterval, .onoffAverageCutoff,
        .onoffFloorLevel, .polyphaseFilterEnable, .polyphaseCenterFreq, .activeFilterCutoff,
        .passiveFilterBw, .signalStrengthValue, .strengthIrqFlag, .interruptPinA,
        .interruptPinB, .onoffThreshold, .demodData, .sampleStrobe, .polyphaseOn,
        .lowPassOn, .filterCenterCode, .filterCutoffCode, .passiveBwCode);
    analog_chain_model chain (.clk_sys, .targetLevel, .targetPhase, .levelSample, .phaseLead);

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // count n strobes, then let the pipeline settle
    task automatic strobes(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 5000) begin
            @(posedge clk_sys);
            k++;
            if (sampleStrobe === 1'b1) n--;
        end
        if (n > 0) begin
            err_total++;
            $display("mismatch strobe wait exp 0 got %0d", n);
            end_sim();
        end else begin
            repeat (4) @(posedge clk_sys);
        end
    endtask

    task automatic t_irq();
        strobes(16);
        strengthIrqLevel <= 8'h50;
        strobes(2);
        chk1("flag", 1'b0, strengthIrqFlag);
        strengthIrqLevel <= 8'h4F;
        irqRoutePinA <= 1'b1;
        strobes(2);
        chk1("flag", 1'b1, strengthIrqFlag);
        chk1("pinA", 1'b1, interruptPinA);
        chk1("pinB", 1'b0, interruptPinB);
        strengthIrqLevel <= 8'hFF;
        strobes(2);
        chk1("flag", 1'b1, strengthIrqFlag);
        strengthIrqClear <= 1'b1;
        @(posedge clk_sys);
        strengthIrqClear <= 1'b0;
        irqRoutePinA <= 1'b0;
        irqRoutePinB <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk1("flag", 1'b0, strengthIrqFlag);
        strengthIrqLevel <= 8'h4F;
        strobes(2);
        chk1("pinB", 1'b1, interruptPinB);
        chk1("pinA", 1'b0, interruptPinA);
        strengthIrqLevel <= 8'hFF;
        strengthIrqClear <= 1'b1;
        @(posedge clk_sys);
        strengthIrqClear <= 1'b0;
        $display("irq test done");
    endtask

    initial begin
        err_total = 0;
        checked = 0;
        rst = 1'b1;
        {onOffMode, strengthIrqClear, irqRoutePinA, irqRoutePinB, polyphaseFilterEnable} = 5'h10;
        {targetPhase, targetLevel, bitRateSetting} = 17'h00000;
        deviationSetting = 8'h03;
        strengthIrqLevel = 8'hFF;
        onoffThresholdKind = KIND_FIXED;
        onoffFloorLevel = 8'h32;
        {onoffDecayStep, onoffDecayInterval, onoffAverageCutoff} = 8'hFF;
        polyphaseCenterFreq = CENTER_CODE;
        activeFilterCutoff = 4'hA;
        passiveFilterBw = 4'h5;
        repeat (4) @(posedge clk_sys);
        chk1("lowPassOn", 1'b1, lowPassOn);
        rst <= 1'b0;
        // filter controls
        polyphaseFilterEnable <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk1("polyphaseOn", 1'b1, polyphaseOn);
        chk8("center", {4'h0, CENTER_CODE}, {4'h0, filterCenterCode});
        chk8("cutoff", 8'h0A, {4'h0, filterCutoffCode});
        chk8("passive", 8'h05, {4'h0, passiveBwCode});
        // sliding mean and fixed threshold
        targetLevel <= 8'h28;
        strobes(17);
        chk8("strength", 8'h28, signalStrengthValue);
        chk8("threshold", 8'h32, onoffThreshold);
        chk1("data", 1'b0, demodData);
        targetLevel <= 8'h50;
        strobes(8);
        chk8("strength", 8'h3C, signalStrengthValue);
        chk1("data", 1'b1, demodData);
        $display("mean test done");
        t_irq();
        // peak mode, decay to floor, reload
        onoffThresholdKind <= KIND_PEAK;
        onoffFloorLevel <= 8'h0A;
        strobes(2);
        chk8("threshold", 8'h44, onoffThreshold);
        targetLevel <= 8'h00;
        strobes(40);
        chk8("threshold", 8'h0A, onoffThreshold);
        chk1("data", 1'b0, demodData);
        targetLevel <= 8'h50;
        strobes(17);
        chk8("threshold", 8'h44, onoffThreshold);
        $display("peak test done");
        // fsk phase data, then average kind
        onOffMode <= 1'b0;
        targetPhase <= 1'b1;
        strobes(2);
        chk1("fsk data", 1'b1, demodData);
        targetPhase <= 1'b0;
        strobes(2);
        chk1("fsk data", 1'b0, demodData);
        onoffThresholdKind <= KIND_AVERAGE;
        strobes(2);
        $display("fsk test done");
        end_sim();
    end
endmodule // tb_top
bind rssi_ook_threshold_demod rssi_ook_threshold_demod_props #(.LEVEL_WIDTH(LEVEL_WIDTH)) props (
    .clk_sys, .rst, .deviationSetting, .strengthIrqLevel, .strengthIrqClear, .irqRoutePinA,
    .irqRoutePinB, .onoffThresholdKind, .onoffFloorLevel, .signalStrengthValue,
    .strengthIrqFlag, .interruptPinA, .interruptPinB, .onoffThreshold, .sampleStrobe,
    .polyphaseOn, .lowPassOn);
`default_nettype wire
